// ---- mcx_exec_core.sv ----
// Execute unit for a subset of a 16-bit minicomputer instruction set.
// Assumes an AHB-Lite master, a memory and a peripheral channel on clock.
`timescale 1ns/1ps
`include "mcx_regs.svh"
module mcx_exec_core #(
  parameter int ILINES = 16
) (
  input  wire logic              clock,
  input  wire logic              rst,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic      [31:0]       hrdata,
  output logic                   mem_req,
  output logic                   mem_we,
  output logic      [15:0]       mem_addr,
  output logic      [15:0]       mem_wdata,
  input  wire logic [15:0]       mem_rdata,
  input  wire logic              mem_ack,
  output logic                   io_req,
  output logic                   io_out,
  output logic      [6:0]        io_dev,
  output logic      [15:0]       io_wdata,
  input  wire logic [15:0]       io_rdata,
  input  wire logic              io_ack,
  input  wire logic [ILINES-1:0] irq_lines,
  input  wire logic [7:0]        chan_num,
  input  wire logic [4:0]        int_irq_set,
  output logic                   irq
);
  if (ILINES < 1 || ILINES > 16) begin : g_chk
    $error("mcx_exec_core: ILINES must be 1..16");
  end

  mcx_pkg::mcx_state_t st_ff;
  mcx_pkg::mcx_cls_t   cls;
  logic [15:0]         gpr_ff [16];
  logic [15:0]         ins_ff;
  logic [15:0]         ext_ff;
  logic [15:0]         pc_ff;
  logic [15:0]         psw_ff;
  logic [15:0]         ea_ff;
  logic [15:0]         opnd_ff;
  logic [3:0]          cnt_ff;
  logic [3:0]          gsel_ff;
  logic [3:0]          ev_ff;
  logic [3:0]          istat_ff;
  logic [3:0]          imask_ff;
  logic [4:0]          intb_ff;
  logic                wr_ff;
  logic [7:0]          wa_ff;
  logic [31:0]         hrdata_ff;
  logic [31:0]         rdv;
  logic [ILINES+7:0]   pins_s;
  logic [15:0]         mul_b;
  logic [31:0]         prod;
  logic [15:0]         new_sp;
  logic [4:0]          rit_clr;
  logic [3:0]          r1;
  logic [3:0]          r2;
  logic [1:0]          md;
  logic                isb;
  logic                sys;
  logic                stk;
  logic                ap;
  logic                busy;
  logic                go;

  function automatic mcx_pkg::mcx_cls_t decode(input logic [15:0] w);
    mcx_pkg::mcx_cls_t c;
    c = mcx_pkg::C_BAD;
    if (w[15]) begin
      case (w[14:11])
        `MCX_OP_MUL: c = mcx_pkg::C_MUL;
        `MCX_OP_CPL: c = mcx_pkg::C_CPL;
        `MCX_OP_STK: begin
          if (w[6:5] == `MCX_MD_REG) c = mcx_pkg::C_RTN;
          else if (w[6:5] == `MCX_MD_CON) c = mcx_pkg::C_MSR;
        end
        default: c = mcx_pkg::C_BAD;
      endcase
    end else begin
      case (w[14:11])
        `MCX_OP_OUT: if (!w[7]) c = mcx_pkg::C_OUT;
        `MCX_OP_RDI: begin
          if (w[7:0] == `MCX_RCA_CODE) c = mcx_pkg::C_RCA;
          else if (w[7:0] == `MCX_RIL_CODE) c = mcx_pkg::C_RIL;
          else if (w[7:6] == `MCX_SST_CODE) c = mcx_pkg::C_SST;
        end
        `MCX_OP_BRF, `MCX_OP_BRB: c = mcx_pkg::C_BR;
        `MCX_OP_RIT: if (w[7] && w[6] && w[0]) c = mcx_pkg::C_RIT;
        `MCX_OP_SMD: if (w[7:0] == `MCX_SMD_CODE) c = mcx_pkg::C_SMD;
        default: c = mcx_pkg::C_BAD;
      endcase
    end
    return c;
  endfunction : decode

  function automatic logic is_priv(input mcx_pkg::mcx_cls_t c, input logic [15:0] w);
    logic p;
    p = 1'b0;
    case (c)
      mcx_pkg::C_MSR: p = (w[10:7] == `MCX_FULL_CNT) || (w[3:0] == `MCX_SP_IDX);
      mcx_pkg::C_CPL: p = (w[10:7] == `MCX_FULL_CNT);
      mcx_pkg::C_RTN: p = (w[3:0] == `MCX_SP_IDX);
      mcx_pkg::C_OUT, mcx_pkg::C_RCA, mcx_pkg::C_RIL,
      mcx_pkg::C_SST, mcx_pkg::C_RIT: p = 1'b1;
      default: p = 1'b0;
    endcase
    return p;
  endfunction : is_priv

  function automatic logic cond_ok(input logic [2:0] f, input logic [2:0] cc);
    return (f == 3'h0) || ((f & cc) != 3'h0);
  endfunction : cond_ok

  assign cls    = decode(ins_ff);
  assign r1     = ins_ff[10:7];
  assign r2     = ins_ff[3:0];
  assign md     = ins_ff[6:5];
  assign isb    = ins_ff[4];
  assign sys    = psw_ff[`MCX_PSW_SYS];
  assign stk    = (r2 == `MCX_SP_IDX);
  assign busy   = (st_ff != mcx_pkg::S_IDLE);
  assign new_sp = gpr_ff[`MCX_SP_IDX] - {11'h000, r1, 1'b0};

  // Pin-level inputs, lines and channel number together
  mcx_sync #(.W(ILINES + 8)) u_sync (
    .clock (clock),
    .rst   (rst),
    .d     ({irq_lines, chan_num}),
    .q     (pins_s)
  );

  assign mul_b = (st_ff == mcx_pkg::S_OPND) ? mem_rdata :
                 (md == `MCX_MD_CON) ? ext_ff : gpr_ff[r2];

  mcx_mul #(.W(16)) u_mul (
    .a (gpr_ff[2]),
    .b (mul_b),
    .p (prod)
  );

  // Bus slave: zero wait, read data registered in the address phase
  assign ap        = hsel && htrans[1] && hready;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_ff;
  assign go        = wr_ff && (wa_ff == `MCX_A_CTRL) && hwdata[0] && !busy;

  always_comb begin
    rdv = 32'h0000_0000;
    case (haddr[7:0])
      `MCX_A_CTRL:  rdv = {31'h0, busy};
      `MCX_A_INSTR: rdv = {16'h0000, ins_ff};
      `MCX_A_EXT:   rdv = {16'h0000, ext_ff};
      `MCX_A_PC:    rdv = {16'h0000, pc_ff};
      `MCX_A_PSW:   rdv = {16'h0000, psw_ff};
      `MCX_A_GSEL:  rdv = {28'h0, gsel_ff};
      `MCX_A_GDATA: rdv = {16'h0000, gpr_ff[gsel_ff]};
      `MCX_A_STAT:  rdv = {19'h0, intb_ff, 4'h0, st_ff};
      `MCX_A_ISTAT: rdv = {28'h0, istat_ff};
      `MCX_A_IMASK: rdv = {28'h0, imask_ff};
      default:      rdv = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      wr_ff     <= 1'b0;
      wa_ff     <= 8'h00;
      hrdata_ff <= 32'h0000_0000;
    end else begin
      wr_ff     <= ap && hwrite;
      wa_ff     <= haddr[7:0];
      hrdata_ff <= (ap && !hwrite) ? rdv : 32'h0000_0000;
    end
  end

  // Software configuration; instruction words locked while busy
  always_ff @(posedge clock) begin
    if (rst) begin
      ins_ff   <= 16'h0000;
      ext_ff   <= 16'h0000;
      gsel_ff  <= 4'h0;
      imask_ff <= 4'h0;
    end else if (wr_ff) begin
      if (wa_ff == `MCX_A_INSTR && !busy) ins_ff <= hwdata[15:0];
      if (wa_ff == `MCX_A_EXT && !busy) ext_ff <= hwdata[15:0];
      if (wa_ff == `MCX_A_GSEL) gsel_ff <= hwdata[3:0];
      if (wa_ff == `MCX_A_IMASK) imask_ff <= hwdata[`MCX_EV_W-1:0];
    end
  end

  // Memory and channel ports
  assign mem_req   = (st_ff == mcx_pkg::S_IND) || (st_ff == mcx_pkg::S_OPND) ||
                     (st_ff == mcx_pkg::S_WR) || (st_ff == mcx_pkg::S_STORE) ||
                     (st_ff == mcx_pkg::S_RTNP) || (st_ff == mcx_pkg::S_RTNS);
  assign mem_we    = (st_ff == mcx_pkg::S_WR) || (st_ff == mcx_pkg::S_STORE);
  assign mem_addr  = ea_ff;
  assign mem_wdata = opnd_ff;
  assign io_req    = (st_ff == mcx_pkg::S_IO);
  assign io_out    = (cls == mcx_pkg::C_OUT);
  assign io_dev    = ins_ff[6:0];
  assign io_wdata  = gpr_ff[3];

  // Sequencer with register file, PC and status word
  always_ff @(posedge clock) begin
    if (rst) begin
      st_ff   <= mcx_pkg::S_IDLE;
      pc_ff   <= 16'h0000;
      psw_ff  <= `MCX_PSW_RST;
      ea_ff   <= 16'h0000;
      opnd_ff <= 16'h0000;
      cnt_ff  <= 4'h0;
      ev_ff   <= 4'h0;
      for (int i = 0; i < 16; i++) gpr_ff[i] <= 16'h0000;
    end else begin
      ev_ff <= 4'h0;
      if (wr_ff && !busy) begin
        if (wa_ff == `MCX_A_PC) pc_ff <= hwdata[15:0];
        if (wa_ff == `MCX_A_PSW) psw_ff <= hwdata[15:0];
        if (wa_ff == `MCX_A_GDATA) gpr_ff[gsel_ff] <= hwdata[15:0];
      end
      case (st_ff)
        mcx_pkg::S_IDLE: if (go) st_ff <= mcx_pkg::S_EXEC;
        mcx_pkg::S_EXEC: begin
          st_ff <= mcx_pkg::S_FIN;
          if (is_priv(cls, ins_ff) && !sys) begin
            ev_ff[`MCX_EV_PRIV] <= 1'b1;
          end else begin
            case (cls)
              mcx_pkg::C_MSR: if (r1 != 4'h0) begin
                cnt_ff  <= 4'h1;
                opnd_ff <= gpr_ff[1];
                ea_ff   <= gpr_ff[r2];
                st_ff   <= mcx_pkg::S_STORE;
              end
              mcx_pkg::C_MUL, mcx_pkg::C_CPL: begin
                if (md[1]) begin
                  ea_ff <= ext_ff + ((r2 != 4'h0) ? gpr_ff[r2] : 16'h0000);
                  st_ff <= md[0] ? mcx_pkg::S_IND : mcx_pkg::S_OPND;
                end else if (md == `MCX_MD_REG && isb) begin
                  ea_ff <= gpr_ff[r2];
                  st_ff <= mcx_pkg::S_OPND;
                end else if (cls == mcx_pkg::C_MUL) begin
                  gpr_ff[1] <= prod[31:16];
                  gpr_ff[2] <= prod[15:0];
                end else if (md == `MCX_MD_REG) begin
                  gpr_ff[r1] <= ~gpr_ff[r2];
                end else begin
                  ev_ff[`MCX_EV_BAD] <= 1'b1;
                end
              end
              mcx_pkg::C_OUT, mcx_pkg::C_SST: st_ff <= mcx_pkg::S_IO;
              mcx_pkg::C_RCA: gpr_ff[3] <= {8'h00, pins_s[7:0]};
              mcx_pkg::C_RIL: gpr_ff[3] <= 16'(pins_s[ILINES+7:8]);
              mcx_pkg::C_BR: begin
                if (cond_ok(ins_ff[10:8], psw_ff[2:0])) begin
                  if (ins_ff[14:11] == `MCX_OP_BRF) pc_ff <= pc_ff + {9'h000, ins_ff[7:1]};
                  else pc_ff <= pc_ff - {9'h000, ins_ff[7:1]};
                end
              end
              mcx_pkg::C_SMD: psw_ff[`MCX_PSW_SYS] <= 1'b0;
              mcx_pkg::C_RTN: begin
                gpr_ff[r2] <= gpr_ff[r2] + `MCX_RTN_STEP;
                ea_ff      <= gpr_ff[r2] + `MCX_RTN_STEP;
                st_ff      <= mcx_pkg::S_RTNP;
              end
              mcx_pkg::C_RIT: st_ff <= mcx_pkg::S_FIN;
              default: ev_ff[`MCX_EV_BAD] <= 1'b1;
            endcase
          end
        end
        mcx_pkg::S_IND: if (mem_ack) begin
          ea_ff <= mem_rdata;
          st_ff <= mcx_pkg::S_OPND;
        end
        mcx_pkg::S_OPND: if (mem_ack) begin
          st_ff <= mcx_pkg::S_FIN;
          if (cls == mcx_pkg::C_MUL) begin
            gpr_ff[1] <= prod[31:16];
            gpr_ff[2] <= prod[15:0];
          end else if (isb) begin
            opnd_ff <= ~mem_rdata;
            st_ff   <= mcx_pkg::S_WR;
          end else begin
            gpr_ff[r1] <= ~mem_rdata;
          end
        end
        mcx_pkg::S_WR: if (mem_ack) st_ff <= mcx_pkg::S_FIN;
        mcx_pkg::S_STORE: if (mem_ack) begin
          if (cnt_ff == r1) begin
            st_ff <= mcx_pkg::S_FIN;
            if (stk) begin
              gpr_ff[`MCX_SP_IDX] <= new_sp;
              if (new_sp < `MCX_SP_MIN) ev_ff[`MCX_EV_OVF] <= 1'b1;
            end
          end else begin
            cnt_ff  <= cnt_ff + 4'h1;
            opnd_ff <= gpr_ff[cnt_ff + 4'h1];
            ea_ff   <= stk ? ea_ff - `MCX_WSTEP : ea_ff + `MCX_WSTEP;
          end
        end
        mcx_pkg::S_RTNP: if (mem_ack) begin
          pc_ff <= mem_rdata;
          ea_ff <= ea_ff - `MCX_WSTEP;
          st_ff <= mcx_pkg::S_RTNS;
        end
        mcx_pkg::S_RTNS: if (mem_ack) begin
          psw_ff <= mem_rdata;
          st_ff  <= mcx_pkg::S_FIN;
        end
        mcx_pkg::S_IO: if (io_ack) begin
          if (cls == mcx_pkg::C_SST) gpr_ff[3] <= io_rdata;
          st_ff <= mcx_pkg::S_FIN;
        end
        mcx_pkg::S_FIN: begin
          ev_ff[`MCX_EV_DONE] <= 1'b1;
          st_ff <= mcx_pkg::S_IDLE;
        end
        default: st_ff <= mcx_pkg::S_IDLE;
      endcase
    end
  end

  // Internal interrupt bits; a new request beats a clear
  assign rit_clr = (st_ff == mcx_pkg::S_EXEC && cls == mcx_pkg::C_RIT && sys) ?
                   ins_ff[5:1] : 5'h00;

  always_ff @(posedge clock) begin
    if (rst) intb_ff <= 5'h00;
    else intb_ff <= (intb_ff & ~rit_clr) | int_irq_set;
  end

  // Sticky events, write one to clear, set wins
  always_ff @(posedge clock) begin
    if (rst) begin
      istat_ff <= 4'h0;
    end else begin
      istat_ff <= (istat_ff & ~((wr_ff && wa_ff == `MCX_A_ISTAT) ?
                  hwdata[`MCX_EV_W-1:0] : 4'h0)) | ev_ff;
    end
  end

  assign irq = |(istat_ff & imask_ff);
endmodule : mcx_exec_core

// ---- mcx_regs.svh ----
// Register offsets, field codes and fixed figures of the execute unit.
// Assumes the includer reads offsets from the low byte of haddr.
`ifndef MCX_REGS_SVH
`define MCX_REGS_SVH

// Register byte offsets
`define MCX_A_CTRL   8'h00
`define MCX_A_INSTR  8'h04
`define MCX_A_EXT    8'h08
`define MCX_A_PC     8'h0c
`define MCX_A_PSW    8'h10
`define MCX_A_GSEL   8'h14
`define MCX_A_GDATA  8'h18
`define MCX_A_STAT   8'h1c
`define MCX_A_ISTAT  8'h20
`define MCX_A_IMASK  8'h24

// Status word
`define MCX_PSW_SYS  15
`define MCX_PSW_RST  16'h8000

// Opcodes, bits 1-4 of the instruction
`define MCX_OP_STK   4'he
`define MCX_OP_MUL   4'h8
`define MCX_OP_CPL   4'hf
`define MCX_OP_OUT   4'h8
`define MCX_OP_RDI   4'h9
`define MCX_OP_BRF   4'ha
`define MCX_OP_BRB   4'hb
`define MCX_OP_RIT   4'h4
`define MCX_OP_SMD   4'h5

// Address modes
`define MCX_MD_REG   2'h0
`define MCX_MD_CON   2'h1

// Short-format selector codes, bits 8-15
`define MCX_RCA_CODE 8'h40
`define MCX_RIL_CODE 8'h00
`define MCX_SMD_CODE 8'h01
`define MCX_SST_CODE 2'h3

// Counts and addresses
`define MCX_FULL_CNT 4'hf
`define MCX_SP_IDX   4'hf
`define MCX_SP_MIN   16'h0080
`define MCX_RTN_STEP 16'h0004
`define MCX_WSTEP    16'h0002

// Event bits in the interrupt status register
`define MCX_EV_DONE  0
`define MCX_EV_PRIV  1
`define MCX_EV_OVF   2
`define MCX_EV_BAD   3
`define MCX_EV_W     4

`endif

// ---- mcx_pkg.sv ----
// Types shared by the execute unit.
// Assumes nothing of its surroundings.
package mcx_pkg;
  typedef enum logic [3:0] {
    C_MSR, C_MUL, C_CPL, C_OUT, C_RCA, C_RIL, C_SST,
    C_BR, C_RIT, C_SMD, C_RTN, C_BAD
  } mcx_cls_t;

  typedef enum logic [3:0] {
    S_IDLE, S_EXEC, S_IND, S_OPND, S_WR, S_STORE, S_RTNP, S_RTNS, S_IO, S_FIN
  } mcx_state_t;
endpackage : mcx_pkg

// ---- mcx_sync.sv ----
// Two-flop synchroniser for pin-level inputs.
// Assumes inputs are quasi-static levels from outside the clock domain.
`timescale 1ns/1ps
module mcx_sync #(
  parameter int W = 8
) (
  input  wire logic         clock,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_ff;

  always_ff @(posedge clock) begin
    if (rst) begin
      meta_ff <= '0;
      q       <= '0;
    end else begin
      meta_ff <= d;
      q       <= meta_ff;
    end
  end
endmodule : mcx_sync

// ---- mcx_mul.sv ----
// Signed single-length multiplier giving a double-length product.
// Assumes operands are stable flop or memory-return values.
`timescale 1ns/1ps
module mcx_mul #(
  parameter int W = 16
) (
  input  wire logic [W-1:0]   a,
  input  wire logic [W-1:0]   b,
  output logic      [2*W-1:0] p
);
  logic [2*W-1:0] a_x;
  logic [2*W-1:0] b_x;

  if (W < 2) begin : g_chk
    $error("mcx_mul: width too small");
  end

  // Sign-extend first so the low 2W bits hold the full signed product
  assign a_x = {{W{a[W-1]}}, a};
  assign b_x = {{W{b[W-1]}}, b};
  assign p   = a_x * b_x;
endmodule : mcx_mul

// ---- mcx_exec_core_properties.sv ----
// Port timing checks for the execute unit.
// Assumes binding into mcx_exec_core; one clock, synchronous reset.
`timescale 1ns/1ps
module mcx_exec_core_properties (
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire logic        mem_req,
  input wire logic        mem_we,
  input wire logic [15:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  input wire logic        mem_ack,
  input wire logic        io_req,
  input wire logic        io_out,
  input wire logic [6:0]  io_dev,
  input wire logic [15:0] io_wdata,
  input wire logic        io_ack,
  input wire logic        irq
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (rst);

  logic rd_ph_ff;

  // Read data phase follows an accepted read address phase
  always_ff @(posedge clock) begin
    if (rst) begin
      rd_ph_ff <= 1'b0;
    end else begin
      rd_ph_ff <= hsel && htrans[1] && hready && !hwrite;
    end
  end

  ready_always_a: assert property (hreadyout)
    else $error("hreadyout low");
  resp_okay_a: assert property (!hresp)
    else $error("error response");
  reset_quiet_a: assert property (disable iff (1'b0)
    rst |=> !mem_req && !io_req && !irq && hrdata == 32'h0)
    else $error("outputs active after reset");
  rdata_idle_a: assert property (!rd_ph_ff |-> hrdata == 32'h0)
    else $error("hrdata outside read data phase");
  upper_zero_a: assert property (rd_ph_ff |-> hrdata[31:16] == 16'h0)
    else $error("upper read bits set");
  mem_hold_a: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr)
    && $stable(mem_we) && $stable(mem_wdata))
    else $error("memory request changed before ack");
  io_hold_a: assert property (
    io_req && !io_ack |=> io_req && $stable(io_dev) && $stable(io_out) && $stable(io_wdata))
    else $error("io request changed before ack");
  io_once_a: assert property (io_ack |=> !io_req)
    else $error("io request held after ack");
  word_step_a: assert property (
    mem_req && mem_we && mem_ack ##1 mem_req && mem_we |->
    mem_addr == $past(mem_addr) + 16'h2 || mem_addr == $past(mem_addr) - 16'h2)
    else $error("store words not consecutive");
endmodule : mcx_exec_core_properties

bind mcx_exec_core mcx_exec_core_properties u_mcx_exec_core_properties (
  .clock(clock), .rst(rst), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
  .mem_ack(mem_ack), .io_req(io_req), .io_out(io_out), .io_dev(io_dev),
  .io_wdata(io_wdata), .io_ack(io_ack), .irq(irq)
);

// ---- mcx_far.sv ----
// Memory and peripheral model on the far side of the execute unit.
// Assumes the bench preloads and inspects mem by hierarchy.
`timescale 1ns/1ps
module mcx_far (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic [1:0]  lat,
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [15:0] mem_addr,
  input  wire logic [15:0] mem_wdata,
  output logic      [15:0] mem_rdata,
  output logic             mem_ack,
  input  wire logic        io_req,
  input  wire logic        io_out,
  input  wire logic [6:0]  io_dev,
  input  wire logic [15:0] io_wdata,
  output logic      [15:0] io_rdata,
  output logic             io_ack
);
  logic [15:0] mem [0:1023];
  logic [1:0]  wait_ff;
  logic [6:0]  out_dev;
  logic [15:0] out_data;
  int          wr_cnt = 0;
  int          out_cnt = 0;

  // Data lines scramble whenever no answer stands
  always @(posedge clock) begin
    mem_ack <= 1'b0;
    io_ack <= 1'b0;
    mem_rdata <= ~mem_rdata;
    io_rdata <= ~io_rdata;
    if (rst) begin
      wait_ff <= 2'h0;
      mem_rdata <= 16'h0;
      io_rdata <= 16'h0;
    end else begin
      if (mem_req && !mem_ack) begin
        wait_ff <= wait_ff + 2'h1;
        if (wait_ff == lat) begin
          mem_ack <= 1'b1;
          wait_ff <= 2'h0;
          if (mem_we) begin
            mem[mem_addr[10:1]] <= mem_wdata;
            wr_cnt <= wr_cnt + 1;
          end else begin
            mem_rdata <= mem[mem_addr[10:1]];
          end
        end
      end
      if (io_req && !io_ack) begin
        io_ack <= 1'b1;
        if (io_out) begin
          out_dev <= io_dev;
          out_data <= io_wdata;
          out_cnt <= out_cnt + 1;
        end else begin
          io_rdata <= {8'h5a, 1'b0, io_dev};
        end
      end
    end
  end
endmodule : mcx_far

// ---- test_minicomputer_instr_exec_subset.sv ----
// Self-checking bench driving the execute unit through its registers.
// Assumes mcx_far on the memory and peripheral ports.
`timescale 1ns/1ps
`include "mcx_regs.svh"
module test_minicomputer_instr_exec_subset;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [15:0] irq_lines = 16'hc3a5;
  logic [7:0]  chan_num = 8'h2d;
  logic [4:0]  int_irq_set = 5'h0;
  logic [1:0]  lat = 2'h0;
  logic        hreadyout, hresp, mem_req, mem_we, mem_ack, io_req, io_out, io_ack, irq;
  logic [31:0] hrdata, rd, ev;
  logic [15:0] mem_addr, mem_wdata, mem_rdata, io_wdata, io_rdata;
  logic [6:0]  io_dev;
  int          fails = 0;
  int          checks = 0;
  int          n0;

  always #20 clock = ~clock;

  mcx_exec_core u_mcx_exec_core (
    .clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata), .mem_ack(mem_ack), .io_req(io_req), .io_out(io_out),
    .io_dev(io_dev), .io_wdata(io_wdata), .io_rdata(io_rdata), .io_ack(io_ack),
    .irq_lines(irq_lines), .chan_num(chan_num), .int_irq_set(int_irq_set), .irq(irq)
  );

  mcx_far u_mcx_far (
    .clock(clock), .rst(rst), .lat(lat), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
    .mem_ack(mem_ack), .io_req(io_req), .io_out(io_out), .io_dev(io_dev),
    .io_wdata(io_wdata), .io_rdata(io_rdata), .io_ack(io_ack)
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %0t: seen %h, expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge clock); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clock); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    check(rd, e);
  endtask : rdc

  task automatic sr(input logic [3:0] i, input logic [15:0] v);
    wr(`MCX_A_GSEL, {28'h0, i});
    wr(`MCX_A_GDATA, {16'h0, v});
  endtask : sr

  task automatic cr(input logic [3:0] i, input logic [15:0] e);
    wr(`MCX_A_GSEL, {28'h0, i});
    rdc(`MCX_A_GDATA, {16'h0, e});
  endtask : cr

  // Runs one instruction; clears all events but stack overflow
  task automatic run(input logic [15:0] ins);
    wr(`MCX_A_INSTR, {16'h0, ins});
    wr(`MCX_A_CTRL, 32'h1);
    do bus(1'b0, `MCX_A_ISTAT, 32'h0); while (rd[0] !== 1'b1);
    ev = rd;
    wr(`MCX_A_ISTAT, ev & 32'hb);
  endtask : run

  task automatic conclude;
    if (fails == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : conclude

  initial begin
    #400000;
    fails++;
    conclude();
  end

  initial begin
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    hsel <= 1'b1;
    @(posedge clock);
    rdc(`MCX_A_PSW, 32'h8000);
    rdc(`MCX_A_STAT, 32'h0);
    rdc(8'h40, 32'h0);
    sr(1, 16'h1111);
    sr(2, 16'h2222);
    sr(15, 16'h0100);
    run(16'hf13f);
    check(u_mcx_far.mem[128], 16'h1111);
    check(u_mcx_far.mem[127], 16'h2222);
    cr(15, 16'h00fc);
    wr(`MCX_A_IMASK, 32'h4);
    for (int i = 0; i < 2; i++) begin
      sr(15, 16'h0084 - 16'(2 * i));
      run(16'hf13f);
      check(ev[2], i[0]);
      check(irq, i[0]);
    end
    wr(`MCX_A_ISTAT, 32'h4);
    rdc(`MCX_A_ISTAT, 32'h0);
    check(irq, 1'b0);
    // Slow memory from here on
    lat <= 2'h2;
    sr(3, 16'h3333);
    sr(6, 16'h0300);
    run(16'hf1b6);
    for (int k = 0; k < 3; k++) begin
      check(u_mcx_far.mem[384 + k], 16'h1111 * (k + 1));
    end
    sr(2, 16'h0003);
    sr(5, 16'hfffe);
    run(16'hc005);
    cr(1, 16'hffff);
    cr(2, 16'hfffa);
    u_mcx_far.mem[32] = 16'h0100;
    wr(`MCX_A_EXT, 32'h40);
    sr(2, 16'h0007);
    run(16'hc040);
    cr(1, 16'h0000);
    cr(2, 16'h0700);
    u_mcx_far.mem[48] = 16'h1234;
    sr(5, 16'h0060);
    run(16'hf815);
    check(u_mcx_far.mem[48], 16'hedcb);
    sr(3, 16'hbeef);
    run(16'h4015);
    check(u_mcx_far.out_dev, 7'h15);
    check(u_mcx_far.out_data, 16'hbeef);
    n0 = u_mcx_far.out_cnt;
    run(16'h4095);
    check(ev[3], 1'b1);
    check(u_mcx_far.out_cnt, n0);
    run(16'h48c3);
    cr(3, 16'h5a43);
    run(16'h4840);
    cr(3, 16'h002d);
    run(16'h4800);
    cr(3, 16'hc3a5);
    wr(`MCX_A_PSW, 32'h8000);
    wr(`MCX_A_PC, 32'h100);
    run(16'h5014);
    rdc(`MCX_A_PC, 32'h10a);
    run(16'h5814);
    rdc(`MCX_A_PC, 32'h100);
    run(16'h5114);
    rdc(`MCX_A_PC, 32'h100);
    wr(`MCX_A_PSW, 32'h8001);
    run(16'h5114);
    rdc(`MCX_A_PC, 32'h10a);
    @(posedge clock);
    int_irq_set <= 5'h1f;
    @(posedge clock);
    int_irq_set <= 5'h0;
    rdc(`MCX_A_STAT, 32'h1f00);
    run(16'h20cb);
    rdc(`MCX_A_STAT, 32'h1a00);
    u_mcx_far.mem[258] = 16'h0456;
    u_mcx_far.mem[257] = 16'h8003;
    sr(15, 16'h0200);
    run(16'hf00f);
    rdc(`MCX_A_PC, 32'h456);
    rdc(`MCX_A_PSW, 32'h8003);
    cr(15, 16'h0204);
    run(16'h2801);
    rdc(`MCX_A_PSW, 32'h0003);
    n0 = u_mcx_far.wr_cnt;
    run(16'hf7b6);
    check(ev[1], 1'b1);
    check(u_mcx_far.wr_cnt, n0);
    run(16'h4840);
    check(ev[1], 1'b1);
    conclude();
  end
endmodule : test_minicomputer_instr_exec_subset
